// ==== rtl/adt_regs.vh ====
// register offsets, field positions, reset values and timing counts for the
// accelerometer result and sensor time registers
// assumes a 100 MHz core clock
`ifndef ADT_REGS_VH
`define ADT_REGS_VH
`define ADT_ADDR_AUX_RESIST_LOW 8'h10
`define ADT_ADDR_AUX_RESIST_HIGH 8'h11
`define ADT_ADDR_ACCEL_X_LOW 8'h12
`define ADT_ADDR_ACCEL_X_HIGH 8'h13
`define ADT_ADDR_ACCEL_Y_LOW 8'h14
`define ADT_ADDR_ACCEL_Y_HIGH 8'h15
`define ADT_ADDR_ACCEL_Z_LOW 8'h16
`define ADT_ADDR_ACCEL_Z_HIGH 8'h17
`define ADT_ADDR_TIMESTAMP_BYTE0 8'h18
`define ADT_ADDR_TIMESTAMP_BYTE1 8'h19
`define ADT_ADDR_TIMESTAMP_BYTE2 8'h1a
`define ADT_RESET_BYTE 8'h00
`define ADT_RESET_SAMPLE 12'h000
`define ADT_RESET_TIME 24'h000000
`define ADT_LOW_NIBBLE_POS 4
`define ADT_TICK_PS 39062500
`define ADT_CLK_PERIOD_PS 10000
`define ADT_TICK_CYCLES (`ADT_TICK_PS / `ADT_CLK_PERIOD_PS)
`endif

// ==== rtl/adt_tick_gen.v ====
// divider that pulses once per sensor time tick
// assumes clock_in at 100 MHz and asynchronous active low reset
`include "adt_regs.vh"
module adt_tick_gen (
  input wire clock_in,
  input wire nrst_in,
  output reg tick_out
);
  localparam integer full_count = `ADT_TICK_CYCLES - 1;
  localparam [11:0] last_count = full_count[11:0];
  reg [11:0] div_ff;
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_ff <= 12'h000;
      tick_out <= 1'b0;
    end else if (div_ff == last_count) begin
      div_ff <= 12'h000;
      tick_out <= 1'b1;
    end else begin
      div_ff <= div_ff + 12'h001;
      tick_out <= 1'b0;
    end
  end
endmodule

// ==== rtl/adt_data_regs.v ====
// read-only result registers: auxiliary r channel, x/y/z acceleration and
// the 24-bit sensor time, with the data-ready flags that reads of the aux and x/y/z registers clear
// assumes the serial interface decodes a one-cycle read strobe with address
`include "adt_regs.vh"
module adt_data_regs (
  input wire clock_in,
  input wire nrst_in,
  input wire rd_strobe_in,
  input wire [7:0] rd_addr_in,
  input wire aux_valid_in,
  input wire [11:0] aux_sample_in,
  input wire acc_valid_in,
  input wire [11:0] acc_x_in,
  input wire [11:0] acc_y_in,
  input wire [11:0] acc_z_in,
  output reg [7:0] rd_data_out,
  output reg rd_valid_out,
  output reg acc_ready_out,
  output reg aux_ready_out
);
  reg [11:0] aux_ff;
  reg [11:0] x_ff;
  reg [11:0] y_ff;
  reg [11:0] z_ff;
  reg [23:0] time_ff;
  reg [7:0] nxt_rd_data;
  wire tick;
  wire rd_acc;
  wire rd_aux;

  // low byte of a split sample: bits 3..0 on top, reserved bits zero
  function [7:0] low_byte;
    input [11:0] s;
    begin
      low_byte = {s[3:0], 4'h0} << (`ADT_LOW_NIBBLE_POS - 4);
    end
  endfunction

  function [7:0] high_byte;
    input [11:0] s;
    begin
      high_byte = s[11:4];
    end
  endfunction

  adt_tick_gen u_tick (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .tick_out(tick)
  );

  assign rd_acc = rd_strobe_in && (rd_addr_in >= `ADT_ADDR_ACCEL_X_LOW) &&
    (rd_addr_in <= `ADT_ADDR_ACCEL_Z_HIGH);
  assign rd_aux = rd_strobe_in && ((rd_addr_in == `ADT_ADDR_AUX_RESIST_LOW) ||
    (rd_addr_in == `ADT_ADDR_AUX_RESIST_HIGH));

  // sample capture
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aux_ff <= `ADT_RESET_SAMPLE;
      x_ff <= `ADT_RESET_SAMPLE;
      y_ff <= `ADT_RESET_SAMPLE;
      z_ff <= `ADT_RESET_SAMPLE;
    end else begin
      if (aux_valid_in) begin
        aux_ff <= aux_sample_in;
      end
      if (acc_valid_in) begin
        x_ff <= acc_x_in;
        y_ff <= acc_y_in;
        z_ff <= acc_z_in;
      end
    end
  end

  // sensor time counter, wraps naturally at 24 bits
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      time_ff <= `ADT_RESET_TIME;
    end else if (tick) begin
      time_ff <= time_ff + 24'h000001;
    end
  end

  // data-ready flags; a new sample in the same cycle as a read wins
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_ready_out <= 1'b0;
      aux_ready_out <= 1'b0;
    end else begin
      if (acc_valid_in) begin
        acc_ready_out <= 1'b1;
      end else if (rd_acc) begin
        acc_ready_out <= 1'b0;
      end
      if (aux_valid_in) begin
        aux_ready_out <= 1'b1;
      end else if (rd_aux) begin
        aux_ready_out <= 1'b0;
      end
    end
  end

  // read mux
  always @* begin
    case (rd_addr_in)
      `ADT_ADDR_AUX_RESIST_LOW: nxt_rd_data = low_byte(aux_ff);
      `ADT_ADDR_AUX_RESIST_HIGH: nxt_rd_data = high_byte(aux_ff);
      `ADT_ADDR_ACCEL_X_LOW: nxt_rd_data = low_byte(x_ff);
      `ADT_ADDR_ACCEL_X_HIGH: nxt_rd_data = high_byte(x_ff);
      `ADT_ADDR_ACCEL_Y_LOW: nxt_rd_data = low_byte(y_ff);
      `ADT_ADDR_ACCEL_Y_HIGH: nxt_rd_data = high_byte(y_ff);
      `ADT_ADDR_ACCEL_Z_LOW: nxt_rd_data = low_byte(z_ff);
      `ADT_ADDR_ACCEL_Z_HIGH: nxt_rd_data = high_byte(z_ff);
      `ADT_ADDR_TIMESTAMP_BYTE0: nxt_rd_data = time_ff[7:0];
      `ADT_ADDR_TIMESTAMP_BYTE1: nxt_rd_data = time_ff[15:8];
      `ADT_ADDR_TIMESTAMP_BYTE2: nxt_rd_data = time_ff[23:16];
      default: nxt_rd_data = `ADT_RESET_BYTE;
    endcase
  end

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= `ADT_RESET_BYTE;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_strobe_in;
      if (rd_strobe_in) begin
        rd_data_out <= nxt_rd_data;
      end
    end
  end
endmodule

// ==== verif/adt_host.sv ====
// host model: issues one-cycle register read strobes
// assumes the bench samples read data one cycle after the strobe
module adt_host (
  input wire logic clock_in,
  output logic strobe_out = 1'b0,
  output logic [7:0] addr_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  task rd(input logic [7:0] a);
    @(posedge clock_in);
    strobe_out <= 1'b1;
    addr_out <= a;
    @(posedge clock_in);
    strobe_out <= 1'b0;
    addr_out <= ~a;
  endtask
endmodule

// ==== verif/adt_chk_checker.sv ====
// assertions on the result register read port
// assumes binding to adt_data_regs
module adt_chk (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic acc_valid_in,
  input wire logic aux_valid_in,
  input wire logic [11:0] acc_x_in,
  input wire logic [11:0] aux_sample_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic acc_ready_out,
  input wire logic aux_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] last_x;
  logic [11:0] last_aux;
  // last captured samples, kept from the inputs alone
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_x <= 12'h000;
      last_aux <= 12'h000;
    end else begin
      if (acc_valid_in) begin
        last_x <= acc_x_in;
      end
      if (aux_valid_in) begin
        last_aux <= aux_sample_in;
      end
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  read_answer_a: assert property (rd_strobe_in |=> rd_valid_out) else $error("no answer");
  read_idle_a: assert property (!rd_strobe_in |=> !rd_valid_out) else $error("stray");
  x_low_a: assert property (rd_strobe_in && rd_addr_in == 8'h12
    |=> rd_data_out == {$past(last_x[3:0]), 4'h0}) else $error("x low");
  x_high_a: assert property (rd_strobe_in && rd_addr_in == 8'h13
    |=> rd_data_out == $past(last_x[11:4])) else $error("x high");
  aux_low_a: assert property (rd_strobe_in && rd_addr_in == 8'h10
    |=> rd_data_out == {$past(last_aux[3:0]), 4'h0}) else $error("aux low");
  acc_clear_a: assert property (rd_strobe_in && rd_addr_in inside {[8'h12:8'h17]} && !acc_valid_in
    |=> !acc_ready_out) else $error("acc flag kept");
  aux_clear_a: assert property (rd_strobe_in && rd_addr_in inside {8'h10, 8'h11} && !aux_valid_in
    |=> !aux_ready_out) else $error("aux flag kept");
  acc_set_a: assert property (acc_valid_in |=> acc_ready_out) else $error("acc flag");
  aux_high_a: assert property (rd_strobe_in && rd_addr_in == 8'h11
    |=> rd_data_out == $past(last_aux[11:4])) else $error("aux high");
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the result and sensor time registers
// assumes adt_host as read master and adt_chk bound below
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, nrst_in = 0, av = 0, cv = 0, st, rv, ar, xr;
  logic [7:0] ad, rd, k;
  logic [11:0] m [4];
  logic [31:0] seed = 32'he144;
  int fail_count = 0, n_tests = 0, i;
  adt_host u_host (.clock_in(clock_in), .strobe_out(st), .addr_out(ad));
  adt_data_regs u_adt_data_regs (.clock_in(clock_in), .nrst_in(nrst_in), .rd_strobe_in(st),
    .rd_addr_in(ad), .aux_valid_in(av), .aux_sample_in(m[0]), .acc_valid_in(cv),
    .acc_x_in(m[1]), .acc_y_in(m[2]), .acc_z_in(m[3]), .rd_data_out(rd),
    .rd_valid_out(rv), .acc_ready_out(ar), .aux_ready_out(xr));
  function logic [11:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[11:0];
  endfunction
  function logic [7:0] eb(logic [7:0] j);
    return j[0] ? m[j/2][11:4] : {m[j/2][3:0], 4'h0};
  endfunction
  task chk(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task rdc(input logic [7:0] a, e);
    u_host.rd(a);
    #1;
    chk(rd, e);
  endtask
  task complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #5 clock_in = ~clock_in;
  initial begin
    foreach (m[j]) m[j] = 12'h000;
    repeat (5) @(posedge clock_in);
    nrst_in <= 1'b1;
    for (k = 0; k < 12; k++) rdc(8'h10 + k, 8'h00);
    for (i = 0; i < 4; i++) begin
      @(posedge clock_in);
      foreach (m[j]) m[j] <= rnd();
      av <= 1'b1;
      cv <= 1'b1;
      @(posedge clock_in);
      av <= 1'b0;
      cv <= 1'b0;
      #1;
      chk(ar, 1'b1);
      chk(xr, 1'b1);
      for (k = 0; k < 8; k++) begin
        rdc(8'h10 + k, eb(k));
        chk(ar, k < 2);
        chk(xr, 1'b0);
      end
    end
    repeat (8000) @(posedge clock_in);
    rdc(8'h18, 8'h02);
    rdc(8'h19, 8'h00);
    complete_run();
  end
endmodule
bind adt_data_regs adt_chk u_chk (.*);
